// ### common/sdr_pkg.sv
// shared constants for the serial converter readout port and its controller
// assumes one 200 MHz system clock on both ends
package sdr_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 5; // system clock period
  localparam int SCLK_PERIOD_NS = 80; // shift clock period made by the controller
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS); // 8 cycles
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);

  // ************************************************************
  // frame shape
  // ************************************************************
  localparam int RES_W = 10; // result width
  localparam int NULL_BITS = 2; // null bits ahead of the result
  localparam int CFG_RISES = 4; // start bit plus three configuration bits
  localparam int RO_LEAD = 2; // read-only variant: output enabled on this falling edge
  localparam logic [3:0] CONV_RISES = 4'hb; // 10.5 clocks: hold edge to 11th rise
  localparam logic [4:0] FIRST_CFG = 5'(CFG_RISES + NULL_BITS + 1);
  localparam logic [4:0] LAST_CFG = 5'(CFG_RISES + NULL_BITS + RES_W);
  localparam logic [4:0] FIRST_RO = 5'(RO_LEAD + NULL_BITS + 1);
  localparam logic [4:0] LAST_RO = 5'(RO_LEAD + NULL_BITS + RES_W);

  // ************************************************************
  // controller register map (byte addresses) and fields
  // ************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] RESULT_OFS = 4'h8;
  localparam int CTRL_GO = 0; // write 1: run one exchange
  localparam int CTRL_SGL = 1; // single_ended_select bit sent
  localparam int CTRL_POL = 2; // polarity bit sent
  localparam int CTRL_RO = 3; // talk to the read-only variant
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
endpackage : sdr_pkg

// ### common/sdr_link_if.sv
// link between the controller and the converter port: select, shift clock
// and one data wire shared by both; the wire level is resolved here
`timescale 1ns/1ps
`default_nettype none
interface sdr_link_if;
  logic cs_n; // chip select, active low, from controller
  logic sclk; // shift clock from controller
  logic h_dat; // controller data drive
  logic h_oe; // controller drives the data wire
  logic d_dat; // converter data drive
  logic d_oe; // converter drives the data wire
  logic line; // resolved wire level
  // a weak pull-down holds the wire low when nobody drives it
  assign line = d_oe ? d_dat : (h_oe ? h_dat : 1'b0);
  modport dev (input cs_n, input sclk, input line, output d_dat, output d_oe);
  modport host (output cs_n, output sclk, output h_dat, output h_oe, input line);
endinterface : sdr_link_if
`default_nettype wire

// ### core/sdr_converter.sv
// converter end of the serial readout port, both variants
// assumes link pins asynchronous to clk; channel codes arrive on clk
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sdr_converter #(
  parameter bit CONFIGURABLE = 1'b1 // 1: four-wire variant, 0: read-only
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  sdr_link_if.dev link, // serial link
  input wire logic [9:0] analog_channel_zero, // level of channel 0 as a code
  input wire logic [9:0] analog_channel_one, // level of channel 1 as a code
  output logic powered, // converter powered up
  output logic sampling, // sample-and-hold tracking
  output logic converting, // conversion in progress
  output logic single_ended_select, // mapping bit taken
  output logic polarity_select, // polarity bit taken
  output logic [9:0] held_code // result of the last conversion
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {DS_OFF, DS_SEEK, DS_CFG, DS_ARM, DS_SHIFT} sdr_dev_state_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic [2:0] ck_s;
    logic [2:0] dt_s;
    logic cs_f;
    logic ck_f;
    logic dt_f;
    sdr_dev_state_t state;
    logic [1:0] cnt;
    logic sgl;
    logic odd;
    logic [10:0] shreg;
    logic [3:0] conv_cnt;
    logic d_dat;
    logic d_oe;
    logic powered;
    logic sampling;
    logic converting;
    logic [9:0] code;
  } sdr_dev_t;

  sdr_dev_t st_reg;
  sdr_dev_t st_next;

  // ************************************************************
  // next state
  // ************************************************************
  // pins pass three flops; a level counts once the second and third agree
  always_comb begin
    logic cs_ok;
    logic ck_ok;
    logic ck_rise;
    logic ck_fall;
    logic din;
    logic [9:0] pos;
    logic [9:0] neg;
    logic [9:0] code_calc;
    // every local starts at a known value so no path leaves a latch behind
    cs_ok = 1'b0;
    ck_ok = 1'b0;
    ck_rise = 1'b0;
    ck_fall = 1'b0;
    din = 1'b0;
    pos = 10'h000;
    neg = 10'h000;
    code_calc = 10'h000;
    st_next = st_reg;
    st_next.cs_s = {st_reg.cs_s[1:0], link.cs_n};
    st_next.ck_s = {st_reg.ck_s[1:0], link.sclk};
    st_next.dt_s = {st_reg.dt_s[1:0], link.line};
    cs_ok = (st_reg.cs_s[1] == st_reg.cs_s[2]);
    ck_ok = (st_reg.ck_s[1] == st_reg.ck_s[2]);
    if (cs_ok) begin
      st_next.cs_f = st_reg.cs_s[2];
    end
    if (ck_ok) begin
      st_next.ck_f = st_reg.ck_s[2];
    end
    if (st_reg.dt_s[1] == st_reg.dt_s[2]) begin
      st_next.dt_f = st_reg.dt_s[2];
    end
    ck_rise = ck_ok & st_reg.ck_s[2] & ~st_reg.ck_f;
    ck_fall = ck_ok & ~st_reg.ck_s[2] & st_reg.ck_f;
    // data changes with the rising edge, so the filtered level before it is the bit
    din = st_reg.dt_f;
    // polarity picks which channel is plus; single-ended ties minus to ground
    pos = st_reg.odd ? analog_channel_one : analog_channel_zero;
    neg = st_reg.odd ? analog_channel_zero : analog_channel_one;
    if (st_reg.sgl) begin
      code_calc = pos;
    end else begin
      // unipolar only: a negative difference reads as zero
      code_calc = (pos > neg) ? (pos - neg) : 10'h000;
    end
    if (st_next.cs_f) begin
      // deselected: port idle, powered down, pins ignored
      st_next.state = DS_OFF;
      st_next.d_oe = 1'b0;
      st_next.d_dat = 1'b0;
      st_next.powered = 1'b0;
      st_next.sampling = 1'b0;
      st_next.converting = 1'b0;
      st_next.cnt = 2'h0;
      st_next.conv_cnt = 4'h0;
    end else begin
      st_next.powered = 1'b1;
      if (st_reg.cs_f) begin
        // falling select opens a fresh exchange
        st_next.state = CONFIGURABLE ? DS_SEEK : DS_ARM;
        st_next.cnt = 2'h0;
        st_next.sgl = 1'b0;
        st_next.odd = 1'b0;
        st_next.sampling = !CONFIGURABLE;
      end else begin
        unique case (st_reg.state)
          DS_OFF: begin
            // select low without a falling edge, reached only from an unused state code: stay idle (reset loads cs_f high)
            st_next.state = DS_OFF;
          end
          DS_SEEK: begin
            if (ck_rise && din) begin
              st_next.state = DS_CFG;
            end
          end
          DS_CFG: begin
            if (ck_rise) begin
              st_next.cnt = st_reg.cnt + 2'h1;
              unique case (st_reg.cnt)
                2'h0: st_next.sgl = din;
                2'h1: begin
                  st_next.odd = din;
                  st_next.sampling = 1'b1;
                end
                default: begin
                  // dummy bit: value dropped, input closed for the frame
                  st_next.state = DS_ARM;
                  st_next.cnt = 2'h1;
                end
              endcase
            end
          end
          DS_ARM: begin
            if (ck_fall) begin
              if (st_reg.cnt == 2'h1) begin
                // hold edge: drive low for the first null bit and start converting
                st_next.state = DS_SHIFT;
                st_next.d_oe = 1'b1;
                st_next.d_dat = 1'b0;
                st_next.shreg = {1'b0, code_calc};
                st_next.code = code_calc;
                st_next.sampling = 1'b0;
                st_next.converting = 1'b1;
                st_next.conv_cnt = 4'h0;
              end else begin
                st_next.cnt = st_reg.cnt + 2'h1;
              end
            end
          end
          DS_SHIFT: begin
            if (ck_rise) begin
              // second null bit, then result MSB first, then zeros
              st_next.d_dat = st_reg.shreg[10];
              st_next.shreg = {st_reg.shreg[9:0], 1'b0};
              if (st_reg.converting) begin
                st_next.conv_cnt = st_reg.conv_cnt + 4'h1;
                if (st_reg.conv_cnt == sdr_pkg::CONV_RISES - 4'h1) begin
                  st_next.converting = 1'b0;
                end
              end
            end
          end
          // three state codes are unused; fall back to idle if one ever appears
          default: st_next.state = DS_OFF;
        endcase
      end
    end
    if (sys_rst) begin
      st_next = '0;
      st_next.cs_s = 3'h7;
      st_next.cs_f = 1'b1;
      st_next.state = DS_OFF;
    end
  end

  // ************************************************************
  // registers and outputs
  // ************************************************************
  // single register stage for the whole state
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign link.d_dat = st_reg.d_dat;
  assign link.d_oe = st_reg.d_oe;
  assign powered = st_reg.powered;
  assign sampling = st_reg.sampling;
  assign converting = st_reg.converting;
  assign single_ended_select = st_reg.sgl;
  assign polarity_select = st_reg.odd;
  assign held_code = st_reg.code;
endmodule : sdr_converter
`default_nettype wire

// ### core/sdr_controller.sv
// controller end: runs one exchange per software order, Avalon-MM slave
// assumes the converter answers within one shift-clock half period
`timescale 1ns/1ps
`default_nettype none
module sdr_controller (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  sdr_link_if.host link, // serial link
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest // high until the request is taken
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {HS_IDLE, HS_SETUP, HS_CLOCK} sdr_host_state_t;

  typedef struct packed {
    logic [2:0] ln_s;
    logic ln_f;
    sdr_host_state_t state;
    logic [3:0] div;
    logic [4:0] rise_cnt;
    logic sclk;
    logic cs_n;
    logic h_dat;
    logic h_oe;
    logic sgl;
    logic pol;
    logic ro;
    logic [9:0] result;
    logic busy;
    logic done;
    logic wait_r;
    logic [31:0] rdata;
  } sdr_host_t;

  sdr_host_t st_reg;
  sdr_host_t st_next;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic req;
    logic [4:0] k;
    logic [4:0] first;
    logic [4:0] last;
    st_next = st_reg;
    req = avs_read | avs_write;
    k = st_reg.rise_cnt + 5'h1;
    first = st_reg.ro ? sdr_pkg::FIRST_RO : sdr_pkg::FIRST_CFG;
    last = st_reg.ro ? sdr_pkg::LAST_RO : sdr_pkg::LAST_CFG;
    // the wire comes from the far end: three flops, second and third agree
    st_next.ln_s = {st_reg.ln_s[1:0], link.line};
    if (st_reg.ln_s[1] == st_reg.ln_s[2]) begin
      st_next.ln_f = st_reg.ln_s[2];
    end
    // one wait state: answer in the cycle after the request appears
    if (req && st_reg.wait_r) begin
      st_next.wait_r = 1'b0;
      unique case (avs_address)
        sdr_pkg::CTRL_OFS: st_next.rdata = {28'h0, st_reg.ro, st_reg.pol, st_reg.sgl, 1'b0};
        sdr_pkg::STATUS_OFS: st_next.rdata = {30'h0, st_reg.done, st_reg.busy};
        sdr_pkg::RESULT_OFS: st_next.rdata = {22'h0, st_reg.result};
        default: st_next.rdata = 32'h0;
      endcase
    end else if (req) begin
      st_next.wait_r = 1'b1;
      if (avs_write && avs_byteenable[0] && avs_address == sdr_pkg::CTRL_OFS && !st_reg.busy) begin
        st_next.sgl = avs_writedata[sdr_pkg::CTRL_SGL];
        st_next.pol = avs_writedata[sdr_pkg::CTRL_POL];
        st_next.ro = avs_writedata[sdr_pkg::CTRL_RO];
        if (avs_writedata[sdr_pkg::CTRL_GO]) begin
          // falling select opens the frame; start bit already on the wire, except in read-only mode where the wire is left undriven
          st_next.busy = 1'b1;
          st_next.done = 1'b0;
          st_next.cs_n = 1'b0;
          st_next.h_oe = !avs_writedata[sdr_pkg::CTRL_RO];
          st_next.h_dat = !avs_writedata[sdr_pkg::CTRL_RO];
          st_next.state = HS_SETUP;
          st_next.div = 4'h0;
          st_next.rise_cnt = 5'h0;
        end
      end
    end
    unique case (st_reg.state)
      HS_IDLE: begin
        st_next.sclk = 1'b0;
      end
      HS_SETUP: begin
        st_next.div = st_reg.div + 4'h1;
        if (st_reg.div == sdr_pkg::SCLK_HALF_LAST) begin
          st_next.div = 4'h0;
          st_next.state = HS_CLOCK;
        end
      end
      HS_CLOCK: begin
        st_next.div = st_reg.div + 4'h1;
        if (st_reg.div == sdr_pkg::SCLK_HALF_LAST) begin
          st_next.div = 4'h0;
          st_next.sclk = ~st_reg.sclk;
          if (!st_reg.sclk) begin
            // rising edge: sample the wire and launch the next bit
            st_next.rise_cnt = k;
            if (k >= first && k <= last) begin
              st_next.result = {st_reg.result[8:0], st_reg.ln_f};
            end
            if (!st_reg.ro) begin
              unique case (k)
                5'h1: st_next.h_dat = st_reg.sgl;
                5'h2: st_next.h_dat = st_reg.pol;
                5'h3: st_next.h_dat = 1'b0;
                // release before the converter drives at the next falling edge
                5'h4: st_next.h_oe = 1'b0;
                default: st_next.h_dat = st_reg.h_dat;
              endcase
            end
          end else if (st_reg.rise_cnt == last) begin
            // shortest frame: raise select right after the last bit
            st_next.cs_n = 1'b1;
            st_next.h_oe = 1'b0;
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
            st_next.state = HS_IDLE;
          end
        end
      end
      default: st_next.state = HS_IDLE;
    endcase
    if (sys_rst) begin
      st_next = '0;
      st_next.cs_n = 1'b1;
      st_next.wait_r = 1'b1;
      st_next.state = HS_IDLE;
    end
  end

  // ************************************************************
  // registers and outputs
  // ************************************************************
  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign link.cs_n = st_reg.cs_n;
  assign link.sclk = st_reg.sclk;
  assign link.h_dat = st_reg.h_dat;
  assign link.h_oe = st_reg.h_oe;
  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = st_reg.wait_r;
endmodule : sdr_controller
`default_nettype wire

// ### tb/sdr_link_props.sv
// link checks: select, shift clock, wire turn-around, power, conversion time
// assumes one clock domain; sees the link signals and converter status only
`timescale 1ns/1ps
`default_nettype none
module sdr_link_props (
  input wire logic clk, // system clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic cs_n, // chip select, active low
  input wire logic sclk, // shift clock
  input wire logic h_dat, // controller data
  input wire logic h_oe, // controller drives wire
  input wire logic d_dat, // converter data
  input wire logic d_oe, // converter drives wire
  input wire logic powered, // converter powered
  input wire logic converting // conversion running
);
  // ********
  // helpers
  // ********
  logic sclk_q;
  logic [4:0] rise_cnt;
  logic [7:0] conv_cnt;
  logic [2:0] hi_cnt;
  // counts restart on deselect, so an aborted frame leaves nothing behind
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_q <= 1'h0;
      rise_cnt <= 5'h00;
      conv_cnt <= 8'h00;
      hi_cnt <= 3'h0;
    end else begin
      sclk_q <= sclk;
      rise_cnt <= cs_n ? 5'h00 : rise_cnt + 5'(sclk && !sclk_q);
      conv_cnt <= converting ? conv_cnt + 8'h01 : 8'h00;
      hi_cnt <= !cs_n ? 3'h0 : hi_cnt + 3'(hi_cnt != 3'h7);
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_select;
    $fell(cs_n);
  endsequence
  sequence s_cfg_sent;
    !cs_n && $fell(h_oe);
  endsequence
  // converter takes the wire, low, about half a clock after the release
  sequence s_turned;
    ##[9:14] ($rose(d_oe) && !d_dat);
  endsequence
  chk_no_fight: assert property (!(h_oe && d_oe))
    else $error("both ends drive the data wire");
  chk_start_bit: assert property (s_select |-> h_oe && h_dat)
    else $error("no start bit at select fall");
  chk_sclk_idle: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("shift clock moves while deselected");
  chk_turn_time: assert property (s_cfg_sent |-> s_turned)
    else $error("converter late or high taking the wire");
  chk_wire_release: assert property (hi_cnt >= 3'h6 |-> !d_oe)
    else $error("converter drives while deselected");
  chk_power_up: assert property (s_select |-> ##[1:5] powered)
    else $error("converter not powered after select");
  chk_power_down: assert property ($rose(cs_n) |-> ##[1:5] !powered)
    else $error("converter still powered after deselect");
  chk_frame_len: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
    else $error("frame rise count wrong");
  chk_conv_len: assert property ($fell(converting) |-> conv_cnt inside {[8'ha5:8'hab]})
    else $error("conversion length wrong");
endmodule : sdr_link_props
`default_nettype wire

// ### tb/serial_adc_readout_port_tb_top.sv
// bench: controller and converter over one link, a configurable and a read-only
// converter on bench-driven links; assumes the package register map and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none
module serial_adc_readout_port_tb_top;
  typedef struct packed {
    logic sgl; // single-ended bit
    logic pol; // polarity bit
    logic [9:0] zero; // channel 0 level
    logic [9:0] one; // channel 1 level
    logic [9:0] code; // expected result
  } sdr_row_t;
  // each mapping, full scale, one step, zero, negative difference clamps
  sdr_row_t rows [6] = '{
    '{1'h1, 1'h0, 10'h3ff, 10'h001, 10'h3ff},
    '{1'h1, 1'h1, 10'h3ff, 10'h001, 10'h001},
    '{1'h1, 1'h1, 10'h000, 10'h000, 10'h000},
    '{1'h0, 1'h0, 10'h200, 10'h0ff, 10'h101},
    '{1'h0, 1'h1, 10'h0ff, 10'h200, 10'h101},
    '{1'h0, 1'h0, 10'h0ff, 10'h200, 10'h000}
  };
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [9:0] chan_zero = 10'h000;
  logic [9:0] chan_one = 10'h000;
  logic powered, converting, powered_b;
  logic sgl_b, pol_b, sampling_c;
  logic [9:0] held_code;
  logic [31:0] rd, lv;
  logic [11:0] word_out;
  logic [11:0] word_ro;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  sdr_link_if link_a ();
  sdr_link_if link_b ();
  sdr_link_if link_c ();
  // ********
  // ends under test
  // ********
  sdr_controller i_sdr_controller (.clk(clk), .sys_rst(sys_rst), .link(link_a.host),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  sdr_converter #(.CONFIGURABLE(1'h1)) i_sdr_converter (.clk(clk), .sys_rst(sys_rst),
    .link(link_a.dev), .analog_channel_zero(chan_zero), .analog_channel_one(chan_one),
    .powered(powered), .sampling(), .converting(converting), .single_ended_select(),
    .polarity_select(), .held_code(held_code));
  // second converter: the bench plays a misbehaving controller here
  sdr_converter #(.CONFIGURABLE(1'h1)) i_sdr_converter_b (.clk(clk), .sys_rst(sys_rst),
    .link(link_b.dev), .analog_channel_zero(chan_zero), .analog_channel_one(chan_one),
    .powered(powered_b), .sampling(), .converting(), .single_ended_select(sgl_b),
    .polarity_select(pol_b), .held_code());
  // read-only converter on a third bench-driven link
  sdr_converter #(.CONFIGURABLE(1'h0)) i_sdr_converter_c (.clk(clk), .sys_rst(sys_rst),
    .link(link_c.dev), .analog_channel_zero(chan_zero), .analog_channel_one(chan_one),
    .powered(), .sampling(sampling_c), .converting(), .single_ended_select(),
    .polarity_select(), .held_code());
  sdr_link_props i_sdr_link_props (.clk(clk), .sys_rst(sys_rst), .cs_n(link_a.cs_n),
    .sclk(link_a.sclk), .h_dat(link_a.h_dat), .h_oe(link_a.h_oe), .d_dat(link_a.d_dat),
    .d_oe(link_a.d_oe), .powered(powered), .converting(converting));
  // ********
  // tasks
  // ********
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // one bus cycle; held until waitrequest is seen low, only the timeout ends it
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask : bus
  task automatic wait_done();
    rd = 32'h0;
    while (rd[sdr_pkg::STAT_DONE] !== 1'h1) begin
      bus(1'h0, sdr_pkg::STATUS_OFS, 32'h0);
    end
  endtask : wait_done
  // one 65 ns shift clock, the nearest whole-clock period to 64 ns, on links b and c;
  // samples both wires and launches nd on link b at the rise
  task automatic pulse(input logic nd, input logic oe);
    word_out = {word_out[10:0], link_b.line};
    word_ro = {word_ro[10:0], link_c.line};
    link_b.sclk <= 1'h1;
    link_c.sclk <= 1'h1;
    link_b.h_dat <= nd;
    link_b.h_oe <= oe;
    repeat (7) @(posedge clk);
    link_b.sclk <= 1'h0;
    link_c.sclk <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pulse
  // leading zeros, then the 4-bit word; wire released at the dummy bit's rise
  task automatic frame_b(input int zeros, input logic [3:0] cfg);
    logic [15:0] sq;
    sq = {12'h000, cfg};
    link_b.cs_n <= 1'h0;
    link_b.h_oe <= 1'h1;
    link_b.h_dat <= sq[zeros + 3];
    repeat (8) @(posedge clk);
    for (int k = 1; k <= zeros + 4; k++) begin
      pulse(k < zeros + 4 ? sq[zeros + 3 - k] : 1'h0, k < zeros + 4);
    end
    repeat (12) pulse(1'h0, 1'h0);
    link_b.cs_n <= 1'h1;
    repeat (8) @(posedge clk);
  endtask : frame_b
  // ********
  // clock and hang guard
  // ********
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // ********
  // sequence of tests
  // ********
  initial begin
    link_b.cs_n = 1'h1;
    link_b.sclk = 1'h0;
    link_b.h_dat = 1'h0;
    link_b.h_oe = 1'h0;
    link_c.cs_n = 1'h1;
    link_c.sclk = 1'h0;
    link_c.h_dat = 1'h0;
    link_c.h_oe = 1'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    foreach (rows[i]) begin
      chan_zero <= rows[i].zero;
      chan_one <= rows[i].one;
      bus(1'h1, sdr_pkg::CTRL_OFS, {29'h0, rows[i].pol, rows[i].sgl, 1'h1});
      wait_done();
      bus(1'h0, sdr_pkg::RESULT_OFS, 32'h0);
      check("result", rd, {22'h0, rows[i].code});
      check("held code", {22'h0, held_code}, {22'h0, rows[i].code});
    end
    // reset in mid-frame brings both ends back to idle
    bus(1'h1, sdr_pkg::CTRL_OFS, 32'h3);
    repeat (60) @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    lv = {26'h0, link_a.cs_n, link_a.sclk, link_a.h_oe, link_a.d_oe, powered, avs_waitrequest};
    check("reset levels", lv, 32'h21);
    sys_rst <= 1'h0;
    @(posedge clk);
    bus(1'h0, sdr_pkg::STATUS_OFS, 32'h0);
    check("status after reset", rd, 32'h0);
    // go without its byte lane, then an unmapped place
    avs_byteenable <= 4'he;
    bus(1'h1, sdr_pkg::CTRL_OFS, 32'h1);
    avs_byteenable <= 4'hf;
    bus(1'h1, 4'hc, 32'hffffffff);
    bus(1'h0, 4'hc, 32'h0);
    check("unmapped read", rd, 32'h0);
    bus(1'h0, sdr_pkg::STATUS_OFS, 32'h0);
    check("no frame", {rd[31:1], link_a.cs_n}, 32'h1);
    // settings without go read back, read-only mode included
    bus(1'h1, sdr_pkg::CTRL_OFS, 32'he);
    bus(1'h0, sdr_pkg::CTRL_OFS, 32'h0);
    check("control readback", rd, 32'he);
    // a second go while busy must not disturb the running exchange
    chan_zero <= 10'h2aa;
    chan_one <= 10'h155;
    bus(1'h1, sdr_pkg::CTRL_OFS, 32'h3);
    bus(1'h1, sdr_pkg::CTRL_OFS, 32'h5);
    wait_done();
    bus(1'h0, sdr_pkg::RESULT_OFS, 32'h0);
    check("result kept", rd, 32'h2aa);
    // leading zeros and a set dummy bit on the bench link
    frame_b(3, 4'hd);
    check("wire frame", {20'h0, word_out}, 32'h2aa);
    check("mapping bits", {30'h0, sgl_b, pol_b}, 32'h2);
    check("wire released", {31'h0, link_b.d_oe}, 32'h0);
    // clock toggling and data driven high while deselected
    repeat (6) pulse(1'h1, 1'h1);
    check("deselected", {30'h0, powered_b, link_b.d_oe}, 32'h0);
    frame_b(0, 4'he);
    check("frame after noise", {20'h0, word_out}, 32'h155);
    // frame cut short after the start bit, then a differential frame
    link_b.cs_n <= 1'h0;
    link_b.h_dat <= 1'h1;
    repeat (8) @(posedge clk);
    pulse(1'h1, 1'h1);
    link_b.cs_n <= 1'h1;
    repeat (8) @(posedge clk);
    frame_b(1, 4'h8);
    check("after abort", {20'h0, word_out}, 32'h155);
    check("mapping after abort", {30'h0, sgl_b, pol_b}, 32'h0);
    // read-only variant: no input word, output after the second falling edge
    link_c.cs_n <= 1'h0;
    repeat (8) @(posedge clk);
    check("sampling from select", {31'h0, sampling_c}, 32'h1);
    repeat (14) pulse(1'h0, 1'h0);
    link_c.cs_n <= 1'h1;
    repeat (8) @(posedge clk);
    check("read-only frame", {20'h0, word_ro}, 32'h155);
    check("read-only idle", {31'h0, sampling_c}, 32'h0);
    wrap_up();
  end
endmodule : serial_adc_readout_port_tb_top
`default_nettype wire
